// file: dv/pipe_phy_model.sv
/*
   Behavioural PHY: answers power requests, streams receive lanes.
   Assumes phyClk is the free-running interface clock made by the bench.
*/
`timescale 1ns/1ns
`include "pipe_port_params.svh"

module pipe_phy_model
(
   // Interface clock and bench control
   input wire logic phyClk,
   input wire logic rxOn,
   // Pins towards the port
   input wire logic [1:0] powerReq,
   output logic phyStatus,
   output pipe_port_pkg::lane_rx_type [`LANE_COUNT-1:0] laneRx
);
   import pipe_port_pkg::*;
   logic [1:0] lastReq = 2'h2;
   int waitCnt = 0;
   initial phyStatus = 1'h0;
   initial laneRx = '0;
   // Completion comes a few cycles late, never in the request cycle
   always @(posedge phyClk)
   begin
      phyStatus <= 1'h0;
      if (powerReq !== lastReq)
      begin
         lastReq <= powerReq;
         waitCnt <= 3;
      end
      else if (waitCnt != 0)
      begin
         waitCnt <= waitCnt - 1;
         phyStatus <= (waitCnt == 1);
      end
   end
   // Out of frame the byte and flag toggle so stale data never looks valid
   always @(posedge phyClk)
      for (int n = 0; n < `LANE_COUNT; n++)
      begin
         laneRx[n].laneRxByte <= rxOn ? 8'hC0 + 8'(n) : ~laneRx[n].laneRxByte;
         laneRx[n].laneRxKcharFlag <= rxOn ? n[0] : ~laneRx[n].laneRxKcharFlag;
         laneRx[n].laneRxStatusCode <= rxOn ? n[1:0] : 2'h0;
         laneRx[n].laneRxValidInd <= rxOn;
         laneRx[n].laneRxIdleInd <= !rxOn;
      end
endmodule // pipe_phy_model

// file: dv/pipe_port_asserts.sv
/*
   Checker for the PIPE port: bus handshakes, reset state, forwarded clock, power wait.
   Assumes binding onto pipe_8bit_phy_port and the constants header on the path.
*/
`timescale 1ns/1ns
`include "pipe_port_params.svh"

module pipe_port_asserts
(
   // Clocks and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic phyClk,
   // Register bus
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [1:0] bresp,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   // PIPE pins
   input wire logic phyStatus,
   input wire logic [1:0] powerReq,
   input wire logic pipeTxClk,
   input pipe_port_pkg::lane_tx_type [`LANE_COUNT-1:0] laneTx
);
   import pipe_port_pkg::*;
   sequence wrTaken;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence rdTaken;
      arvalid && arready;
   endsequence
   a_reset_outputs:
   assert property (@(posedge ref_clk) disable iff (!rst_n) $rose(rst_n) |->
      laneTx == {`LANE_COUNT{12'h002}} && powerReq == `PWR_RESET && !bvalid && !rvalid) else $error("reset state wrong");
   a_txclk_running:
   assert property (@(edge phyClk) disable iff (!rst_n) rst_n[*8] |-> ##[0:1] $changed(pipeTxClk))
      else $error("transmit clock stopped");
   a_write_answer:
   assert property (@(posedge ref_clk) disable iff (!rst_n) wrTaken |=> !awready && !wready ##1 bvalid)
      else $error("write answer late");
   a_write_hold:
   assert property (@(posedge ref_clk) disable iff (!rst_n) bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped");
   a_write_release:
   assert property (@(posedge ref_clk) disable iff (!rst_n) bvalid && bready |=> !bvalid && awready && wready)
      else $error("write channel not freed");
   a_read_answer:
   assert property (@(posedge ref_clk) disable iff (!rst_n) rdTaken |=> rvalid && !arready)
      else $error("read answer late");
   a_read_hold:
   assert property (@(posedge ref_clk) disable iff (!rst_n) rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped");
   a_read_release:
   assert property (@(posedge ref_clk) disable iff (!rst_n) rvalid && rready |=> !rvalid && arready)
      else $error("read channel not freed");
   a_power_held:
   assert property (@(posedge phyClk) disable iff (!rst_n) $changed(powerReq) ##1 (!phyStatus)[*2] |=> $stable(powerReq))
      else $error("power request changed while waiting");
endmodule // pipe_port_asserts

bind pipe_8bit_phy_port pipe_port_asserts i_pipe_port_asserts (.ref_clk, .rst_n, .phyClk, .awvalid, .awready,
   .wvalid, .wready, .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata, .phyStatus,
   .powerReq, .pipeTxClk, .laneTx);

// file: dv/testbench.sv
/*
   Self-checking bench for the PIPE port: bus tasks, lane, status and power checks.
   Assumes the PHY model and the checker are compiled before it.
*/
`timescale 1ns/1ns
`include "pipe_port_params.svh"

module testbench;
   import pipe_port_pkg::*;
   logic ref_clk = 1'h0;
   logic phyClk = 1'h0;
   logic rst_n = 1'h0;
   logic rxOn = 1'h1;
   logic awvalid, wvalid, bready, arvalid, rready, phyStatus, awready, wready, bvalid, arready, rvalid, pipeTxClk;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, powerReq;
   lane_rx_type [`LANE_COUNT-1:0] laneRx;
   lane_tx_type [`LANE_COUNT-1:0] laneTx;
   int badCount = 0;
   int checked = 0;
   always #50 ref_clk = ~ref_clk;
   // Link clock offset so its edges never meet the bus clock
   initial #37 forever #80 phyClk = ~phyClk;
   pipe_8bit_phy_port i_pipe_8bit_phy_port (.ref_clk, .rst_n, .awvalid, .awready, .awaddr, .wvalid, .wready,
      .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
      .phyClk, .phyStatus, .powerReq, .pipeTxClk, .laneRx, .laneTx);
   pipe_phy_model i_pipe_phy_model (.phyClk, .rxOn, .powerReq, .phyStatus, .laneRx);
   task automatic conclude;
      $display("checks %0d mismatches %0d", checked, badCount);
      if (badCount == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
      checked++;
      if (g !== e)
      begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         badCount++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do
      begin
         @(posedge ref_clk);
         if (awvalid && awready)
            awvalid <= 1'h0;
         if (wvalid && wready)
            wvalid <= 1'h0;
      end
      while ((awvalid && !awready) || (wvalid && !wready));
      while (!bvalid) @(posedge ref_clk);
      chk("bresp", 48'(er), 48'(bresp));
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do @(posedge ref_clk); while (!arready);
      arvalid <= 1'h0;
      while (!rvalid) @(posedge ref_clk);
      chk("rdata", 48'(ed), 48'(rdata));
      chk("rresp", 48'(er), 48'(rresp));
   endtask
   // Lane fields from the data and control words: byte, K flag, compliance, idle, invert
   function automatic logic [47:0] expTx(input logic [31:0] c, input logic [31:0] t);
      logic [47:0] e;
      for (int n = 0; n < 4; n++)
         e[12*n +: 12] = {t[8*n +: 8], c[16+n], c[8+n], c[4+n], c[12+n]};
      return e;
   endfunction
   task automatic waitTx(input logic [47:0] e);
      int k;
      k = 0;
      while (laneTx !== e && k < 60)
      begin
         @(posedge ref_clk);
         k++;
      end
      chk("laneTx", e, laneTx);
   endtask
   initial
   begin
      {awvalid, wvalid, bready, arvalid, rready, wstrb} = '0;
      {awaddr, araddr, wdata} = '0;
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'h1;
      @(posedge ref_clk);
      chk("laneTx reset", {4{12'h002}}, laneTx);
      rd(`ADDR_CTRL, 32'h000000F2, `RESP_OKAY);
      wr(`ADDR_CTRL, 32'h000A5360, 4'hF, `RESP_OKAY);
      wr(`ADDR_TXDATA, 32'h44332211, 4'hF, `RESP_OKAY);
      waitTx(expTx(32'h000A5360, 32'h44332211));
      chk("powerReq", 48'h0, 48'(powerReq));
      wr(`ADDR_TXDATA, 32'hFFFFFF99, 4'h1, `RESP_OKAY);
      waitTx(expTx(32'h000A5360, 32'h44332299));
      wr(`ADDR_STATUS, 32'hFFFFFFFF, 4'hF, `RESP_OKAY);
      repeat (20) @(posedge ref_clk);
      rd(`ADDR_STATUS, 32'h00AE40F0, `RESP_OKAY);
      rd(`ADDR_RXDATA, 32'hC3C2C1C0, `RESP_OKAY);
      rxOn <= 1'h0;
      repeat (10) @(posedge ref_clk);
      rd(`ADDR_RXDATA, 32'hC3C2C1C0, `RESP_OKAY);
      wr(8'h10, 32'h0, 4'hF, `RESP_DECERR);
      rd(8'h40, 32'h0, `RESP_DECERR);
      wr(`ADDR_CTRL, 32'h000A5363, 4'hF, `RESP_OKAY);
      repeat (20) @(posedge ref_clk);
      chk("powerReq", 48'h3, 48'(powerReq));
      rst_n <= 1'h0;
      repeat (5) @(posedge ref_clk);
      chk("laneTx reset", {4{12'h002}}, laneTx);
      chk("powerReq reset", 48'h2, 48'(powerReq));
      rst_n <= 1'h1;
      @(posedge ref_clk);
      rd(`ADDR_CTRL, 32'h000000F2, `RESP_OKAY);
      conclude;
   end
   initial
   begin
      #100000;
      $display("[ERR] watchdog expected done seen hang");
      badCount++;
      conclude;
   end
endmodule // testbench

// file: logic/pipe_8bit_phy_port.sv
/*
   Link-layer end of an 8-bit PIPE port towards an external PHY, with an
   AXI4-Lite register slave on ref_clk and the lane logic on the PHY clock.
   Assumes the PHY launches and samples all lane pins on phyClk and that
   rst_n is the active-low protocol reset.
*/
// Implementation choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "pipe_port_params.svh"

module pipe_8bit_phy_port
(
   // System clock and protocol reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // AXI4-Lite write channels
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // AXI4-Lite read channels
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // PHY clock and common PIPE signals
   input wire logic phyClk,
   input wire logic phyStatus,
   output logic [1:0] powerReq,
   output logic pipeTxClk,
   // Per-lane PIPE signals
   input pipe_port_pkg::lane_rx_type [`LANE_COUNT-1:0] laneRx,
   output pipe_port_pkg::lane_tx_type [`LANE_COUNT-1:0] laneTx
);
   import pipe_port_pkg::*;

   // Register side state
   logic awreadyReg;
   logic wreadyReg;
   logic bvalidReg;
   logic [1:0] brespReg;
   logic arreadyReg;
   logic rvalidReg;
   logic [31:0] rdataReg;
   logic [1:0] rrespReg;
   logic [7:0] awaddrHeld;
   logic [31:0] wdataHeld;
   logic [3:0] wstrbHeld;
   ctrl_type ctrlReg;
   logic [31:0] txBytesReg;
   logic dirtyReg;
   link_ctl_type ctlSendReg;
   logic ctlReqReg;
   logic ctlAckSync1;
   logic ctlAckSync2;
   logic stReqSync1;
   logic stReqSync2;
   logic stAckReg;
   link_stat_type statRefReg;

   // Link side state
   logic linkRstSync1;
   logic linkRstSync2;
   logic ctlReqSync1;
   logic ctlReqSync2;
   logic ctlSeenReg;
   link_ctl_type ctlLinkReg;
   logic stReqReg;
   logic stAckSync1;
   logic stAckSync2;
   link_stat_type stSendReg;
   lane_rx_type [`LANE_COUNT-1:0] rxCapReg;
   logic phyStatusReg;
   lane_tx_type [`LANE_COUNT-1:0] txOutReg;
   logic [1:0] powerReqReg;
   power_state_type powerStateReg;
   power_state_type powerStateNext;
   logic txClkReg;
   logic [31:0] rxHoldReg;
   status_type liveStatus;

   // Bus decode
   wire linkRst_n = linkRstSync2;
   wire awFire = awvalid && awreadyReg;
   wire wFire = wvalid && wreadyReg;
   wire writeGo = !awreadyReg && !wreadyReg && !bvalidReg;
   wire arFire = arvalid && arreadyReg;
   wire hitCtrl = awaddrHeld == `ADDR_CTRL;
   wire hitTxData = awaddrHeld == `ADDR_TXDATA;
   wire writeMapped = hitCtrl || hitTxData || awaddrHeld == `ADDR_STATUS || awaddrHeld == `ADDR_RXDATA;
   wire readCtrl = araddr == `ADDR_CTRL;
   wire readTxData = araddr == `ADDR_TXDATA;
   wire readStatus = araddr == `ADDR_STATUS;
   wire readRxData = araddr == `ADDR_RXDATA;
   wire readMapped = readCtrl || readTxData || readStatus || readRxData;
   wire [31:0] byteMask;
   wire [31:0] ctrlWord = {{(32 - $bits(ctrl_type)){1'b0}}, ctrlReg};
   wire [31:0] statusWord = {{(32 - $bits(status_type)){1'b0}}, statRefReg.status};
   wire [31:0] ctrlMerged = (ctrlWord & ~byteMask) | (wdataHeld & byteMask);
   wire [31:0] txMerged = (txBytesReg & ~byteMask) | (wdataHeld & byteMask);
   wire [31:0] readMux = readCtrl ? ctrlWord :
                         readTxData ? txBytesReg :
                         readStatus ? statusWord :
                         readRxData ? statRefReg.rxBytes : 32'h0000_0000;
   wire ctlLaunch = dirtyReg && (ctlAckSync2 == ctlReqReg);
   wire ctlArrive = ctlReqSync2 != ctlSeenReg;
   wire stLaunch = stAckSync2 == stReqReg;
   wire stArrive = stReqSync2 != stAckReg;

   genvar b;
   generate
      for (b = 0; b < 4; b = b + 1)
      begin : gen_mask
         assign byteMask[8*b +: 8] = {8{wstrbHeld[b]}};
      end
   endgenerate

   assign awready = awreadyReg;
   assign wready = wreadyReg;
   assign bvalid = bvalidReg;
   assign bresp = brespReg;
   assign arready = arreadyReg;
   assign rvalid = rvalidReg;
   assign rdata = rdataReg;
   assign rresp = rrespReg;
   assign powerReq = powerReqReg;
   assign pipeTxClk = txClkReg;
   assign laneTx = txOutReg;

   // Write address and data are taken in either order, answered once both held
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         awreadyReg <= 1'b1;
         wreadyReg <= 1'b1;
         bvalidReg <= 1'b0;
         brespReg <= `RESP_OKAY;
         awaddrHeld <= 8'h00;
         wdataHeld <= 32'h0000_0000;
         wstrbHeld <= 4'h0;
      end
      else
      begin
         if (awFire)
         begin
            awreadyReg <= 1'b0;
            awaddrHeld <= awaddr;
         end
         if (wFire)
         begin
            wreadyReg <= 1'b0;
            wdataHeld <= wdata;
            wstrbHeld <= wstrb;
         end
         if (writeGo)
         begin
            bvalidReg <= 1'b1;
            brespReg <= writeMapped ? `RESP_OKAY : `RESP_DECERR;
         end
         if (bvalidReg && bready)
         begin
            bvalidReg <= 1'b0;
            awreadyReg <= 1'b1;
            wreadyReg <= 1'b1;
         end
      end
   end

   // Control registers; reset values leave lanes idle
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrlReg <= '0;
         ctrlReg.powerReq <= `PWR_RESET;
         ctrlReg.txIdle <= `TXIDLE_RESET;
         txBytesReg <= 32'h0000_0000;
      end
      else if (writeGo && hitCtrl)
      begin
         ctrlReg <= ctrl_type'(ctrlMerged[$bits(ctrl_type)-1:0]);
      end
      else if (writeGo && hitTxData)
      begin
         txBytesReg <= txMerged;
      end
   end

   // Read channel answers one cycle after the address is taken
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         arreadyReg <= 1'b1;
         rvalidReg <= 1'b0;
         rdataReg <= 32'h0000_0000;
         rrespReg <= `RESP_OKAY;
      end
      else if (arFire)
      begin
         arreadyReg <= 1'b0;
         rvalidReg <= 1'b1;
         rdataReg <= readMux;
         rrespReg <= readMapped ? `RESP_OKAY : `RESP_DECERR;
      end
      else if (rvalidReg && rready)
      begin
         arreadyReg <= 1'b1;
         rvalidReg <= 1'b0;
      end
   end

   // Control word crosses by toggle handshake; a write during launch stays dirty
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dirtyReg <= 1'b0;
         ctlReqReg <= 1'b0;
         ctlSendReg <= '0;
         ctlSendReg.ctrl.powerReq <= `PWR_RESET;
         ctlSendReg.ctrl.txIdle <= `TXIDLE_RESET;
         ctlAckSync1 <= 1'b0;
         ctlAckSync2 <= 1'b0;
      end
      else
      begin
         ctlAckSync1 <= ctlSeenReg;
         ctlAckSync2 <= ctlAckSync1;
         dirtyReg <= writeGo ? 1'b1 : (ctlLaunch ? 1'b0 : dirtyReg);
         if (ctlLaunch)
         begin
            ctlSendReg <= {ctrlReg, txBytesReg};
            ctlReqReg <= ~ctlReqReg;
         end
      end
   end

   // Status snapshots arrive from the link side by the reverse handshake
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stReqSync1 <= 1'b0;
         stReqSync2 <= 1'b0;
         stAckReg <= 1'b0;
         statRefReg <= '0;
      end
      else
      begin
         stReqSync1 <= stReqReg;
         stReqSync2 <= stReqSync1;
         if (stArrive)
         begin
            stAckReg <= stReqSync2;
            statRefReg <= stSendReg;
         end
      end
   end

   // Link reset: asserts at once, releases on phyClk
   always_ff @(posedge phyClk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         linkRstSync1 <= 1'b0;
         linkRstSync2 <= 1'b0;
      end
      else
      begin
         linkRstSync1 <= 1'b1;
         linkRstSync2 <= linkRstSync1;
      end
   end

   // Link side of both handshakes
   always_ff @(posedge phyClk or negedge linkRst_n)
   begin
      if (!linkRst_n)
      begin
         ctlReqSync1 <= 1'b0;
         ctlReqSync2 <= 1'b0;
         ctlSeenReg <= 1'b0;
         ctlLinkReg <= '0;
         ctlLinkReg.ctrl.powerReq <= `PWR_RESET;
         ctlLinkReg.ctrl.txIdle <= `TXIDLE_RESET;
         stAckSync1 <= 1'b0;
         stAckSync2 <= 1'b0;
         stReqReg <= 1'b0;
         stSendReg <= '0;
      end
      else
      begin
         ctlReqSync1 <= ctlReqReg;
         ctlReqSync2 <= ctlReqSync1;
         stAckSync1 <= stAckReg;
         stAckSync2 <= stAckSync1;
         if (ctlArrive)
         begin
            ctlSeenReg <= ctlReqSync2;
            ctlLinkReg <= ctlSendReg;
         end
         if (stLaunch)
         begin
            stReqReg <= ~stReqReg;
            stSendReg <= {liveStatus, rxHoldReg};
         end
      end
   end

   // Power request held until the PHY reports completion
   always_comb
   begin
      powerStateNext = powerStateReg;
      case (powerStateReg)
         PWR_STEADY:
            if (ctlLinkReg.ctrl.powerReq != powerReqReg)
            begin
               powerStateNext = PWR_WAIT;
            end
         PWR_WAIT:
            if (phyStatusReg)
            begin
               powerStateNext = PWR_STEADY;
            end
         default:
            powerStateNext = PWR_STEADY;
      endcase
   end

   always_ff @(posedge phyClk or negedge linkRst_n)
   begin
      if (!linkRst_n)
      begin
         powerStateReg <= PWR_STEADY;
         powerReqReg <= `PWR_RESET;
         phyStatusReg <= 1'b0;
         txClkReg <= 1'b0;
      end
      else
      begin
         powerStateReg <= powerStateNext;
         phyStatusReg <= phyStatus;
         txClkReg <= `HAS_TX_CLK & ~txClkReg;
         if (powerStateReg == PWR_STEADY)
         begin
            powerReqReg <= ctlLinkReg.ctrl.powerReq;
         end
      end
   end

   // Status fields of absent lanes read as zero
   always_comb
   begin
      liveStatus = '0;
      liveStatus.powerBusy = powerStateReg == PWR_WAIT;
      for (int i = 0; i < `LANE_COUNT; i++)
      begin
         liveStatus.rxKFlag[i] = rxCapReg[i].laneRxKcharFlag;
         liveStatus.rxStatus[2*i +: 2] = rxCapReg[i].laneRxStatusCode;
         liveStatus.rxIdle[i] = rxCapReg[i].laneRxIdleInd;
         liveStatus.rxValid[i] = rxCapReg[i].laneRxValidInd;
      end
   end

   // One slice per configured lane; a single-lane build has no lanes 1 to 3
   genvar n;
   generate
      for (n = 0; n < `LANE_COUNT; n = n + 1)
      begin : gen_lane
         always_ff @(posedge phyClk or negedge linkRst_n)
         begin
            if (!linkRst_n)
            begin
               rxCapReg[n] <= '0;
               rxHoldReg[8*n +: 8] <= 8'h00;
               txOutReg[n] <= '0;
               txOutReg[n].laneTxIdleCtl <= 1'b1;
            end
            else
            begin
               rxCapReg[n] <= laneRx[n];
               if (rxCapReg[n].laneRxValidInd)
               begin
                  rxHoldReg[8*n +: 8] <= rxCapReg[n].laneRxByte;
               end
               txOutReg[n].laneTxByte <= ctlLinkReg.txBytes[8*n +: 8];
               txOutReg[n].laneTxKcharFlag <= ctlLinkReg.ctrl.txKFlag[n];
               txOutReg[n].laneTxComplianceCtl <= ctlLinkReg.ctrl.txCompliance[n];
               txOutReg[n].laneTxIdleCtl <= ctlLinkReg.ctrl.txIdle[n];
               txOutReg[n].laneRxInvertCtl <= ctlLinkReg.ctrl.rxInvert[n];
            end
         end
      end
      if (`LANE_COUNT < 4)
      begin : gen_no_lanes
         assign rxHoldReg[31:8*`LANE_COUNT] = '0;
      end
   endgenerate

endmodule // pipe_8bit_phy_port

// file: logic/pipe_port_params.svh
/*
   Constants of the 8-bit PIPE port: lane count, transmit clock option,
   register byte addresses, reset values and bus answers.
   Assumes inclusion by the package, the port module and the dv files.
*/
`ifndef PIPE_PORT_PARAMS_SVH
`define PIPE_PORT_PARAMS_SVH

`define LANE_COUNT 4
`define HAS_TX_CLK 1'h1
`define ADDR_CTRL 8'h00
`define ADDR_TXDATA 8'h04
`define ADDR_STATUS 8'h08
`define ADDR_RXDATA 8'h0C
`define PWR_RESET 2'h2
`define TXIDLE_RESET 4'hF
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

// file: logic/pipe_port_pkg.sv
/*
   Types of the 8-bit PIPE port: per-lane pin bundles, the control word
   software writes, the status word it reads, and the power state machine.
   Assumes the constants header is on the include path.
*/
package pipe_port_pkg;
`include "pipe_port_params.svh"

   typedef struct packed {
      logic [7:0] laneTxByte;
      logic laneTxKcharFlag;
      logic laneTxComplianceCtl;
      logic laneTxIdleCtl;
      logic laneRxInvertCtl;
   } lane_tx_type;

   typedef struct packed {
      logic [7:0] laneRxByte;
      logic laneRxKcharFlag;
      logic [1:0] laneRxStatusCode;
      logic laneRxValidInd;
      logic laneRxIdleInd;
   } lane_rx_type;

   typedef struct packed {
      logic [3:0] txKFlag;
      logic [3:0] rxInvert;
      logic [3:0] txCompliance;
      logic [3:0] txIdle;
      logic [1:0] spare;
      logic [1:0] powerReq;
   } ctrl_type;

   typedef struct packed {
      logic [3:0] rxKFlag;
      logic [7:0] rxStatus;
      logic [3:0] rxIdle;
      logic [3:0] rxValid;
      logic [2:0] spare;
      logic powerBusy;
   } status_type;

   typedef struct packed {
      ctrl_type ctrl;
      logic [31:0] txBytes;
   } link_ctl_type;

   typedef struct packed {
      status_type status;
      logic [31:0] rxBytes;
   } link_stat_type;

   typedef enum logic [1:0] {
      PWR_STEADY = 2'h0,
      PWR_WAIT = 2'h1
   } power_state_type;

endpackage
